// file: shared/dmci_pkg.sv
// constants, encodings and state type of the ddr2 bring-up controller
package dmci_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_POWER_US    = 200;
  // least times round up to whole cycles
  localparam int POWER_CYC =
    (T_POWER_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_CKE_NS      = 400;
  localparam int CKE_CYC = (T_CKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DLL_LOCK_CYC  = 200;
  localparam int MRD_CYC       = 2;
  localparam int RP_CYC        = 3;
  localparam int RFC_CYC       = 11;
  localparam int TMR_W         = 15;
  localparam int ADDR_W        = 13;

  localparam logic [2:0] AL_MAX = 3'h6;
  localparam logic [2:0] CL_MIN = 3'h3;

  // {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_NOP  = 4'h7;
  localparam logic [3:0] CMD_PRE  = 4'h2;
  localparam logic [3:0] CMD_REF  = 4'h1;
  localparam logic [3:0] CMD_LM   = 4'h0;

  // {ba1, ba0}
  localparam logic [1:0] BA_MR    = 2'h0;
  localparam logic [1:0] BA_EMR   = 2'h1;
  localparam logic [1:0] BA_EMR2  = 2'h2;
  localparam logic [1:0] BA_EMR3  = 2'h3;

  localparam int A10_POS     = 10;
  localparam int DLLRST_POS  = 8;
  localparam int SRF_POS     = 7;
  localparam int OCD_POS     = 7;
  localparam int AL_POS      = 3;
  localparam int CL_POS      = 4;
  localparam logic [2:0] OCD_DEFAULT = 3'h7;
  localparam logic [2:0] OCD_EXIT    = 3'h0;
  // software-owned fields: mode reg bl, bt, wr, pd; ext reg ds, odt, dqs
  localparam logic [12:0] MR_USER_MASK  = 13'h1e0f;
  localparam logic [12:0] EMR_USER_MASK = 13'h1c46;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h00, ST_PWR  = 5'h01, ST_CKEW = 5'h03, ST_PRE1 = 5'h02,
    ST_EMR2 = 5'h06, ST_EMR3 = 5'h07, ST_EDLL = 5'h05, ST_MRST = 5'h04,
    ST_PRE2 = 5'h0c, ST_REF1 = 5'h0d, ST_REF2 = 5'h0f, ST_MROP = 5'h0e,
    ST_OCDD = 5'h0a, ST_OCDX = 5'h0b, ST_LOCK = 5'h09, ST_DONE = 5'h08,
    ST_UPD  = 5'h18, ST_UWT  = 5'h19
  } dmci_state_type;
endpackage

// file: shared/dmci_tmr_if.sv
// gap timer hookup between sequencer and timer
`timescale 1ns/100ps
interface dmci_tmr_if;
  logic                       load;
  logic [dmci_pkg::TMR_W-1:0] value;
  logic                       done;
  modport ctl (output load, output value, input done);
  modport tmr (input load, input value, output done);
endinterface

// file: core/dmci_timer.sv
// down counter that spaces commands on the memory bus
`timescale 1ns/100ps
module dmci_timer (
  input wire logic clk,
  input wire logic resetn,
  dmci_tmr_if.tmr  t
);
  logic [dmci_pkg::TMR_W-1:0] count_reg;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      count_reg <= '0;
    end else if (t.load) begin
      count_reg <= t.value;
    end else if (count_reg != '0) begin
      count_reg <= count_reg - 1'b1;
    end
  end

  assign t.done = (count_reg == '0);
endmodule

// file: core/dmci_init_ctrl.sv
// ddr2 power-up sequencer and mode register loader, controller side
// Operation
// - additive latency 0 to 6 only; reserved codes never sent
// - additive latency must not exceed tRCD minimum in clocks
// - write latency is read latency minus one clock
// - EMR2 bit 7 set for faster refresh when case runs hot
// - EMR2/EMR3 loaded only with banks idle, then tMRD wait
// - bits above 12 and bank bit 2 always written zero
// - driver calibration stays at default, only default and exit
// - NOP only for 200 us after start, then raise CKE
// - CKE stays high for the rest of bring-up
// - wait 400 ns after CKE before first precharge all
// - load EMR2 next, only bit 7 may be set
// - load EMR3 next with all bits zero
// - load EMR with DLL enabled and other bits zero
// - load MR with DLL reset bit; DLL needs 200 clocks
// - after DLL reset, precharge all then two refreshes
// - load MR with operating values and DLL reset bit low
// - EMR with driver default bits set, then with them clear
// - no normal access before 200 clocks after DLL reset
// - CAS latency 3 to 7 only
`timescale 1ns/100ps
module dmci_init_ctrl #(
  parameter int unsigned P_POWER_CYC = dmci_pkg::POWER_CYC,
  parameter int unsigned P_MRD_CYC   = dmci_pkg::MRD_CYC,
  parameter int unsigned P_RP_CYC    = dmci_pkg::RP_CYC,
  parameter int unsigned P_RFC_CYC   = dmci_pkg::RFC_CYC
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        init_start,
  input  wire logic [2:0]  cfg_cl,
  input  wire logic [2:0]  cfg_al,
  input  wire logic [3:0]  cfg_trcd,
  input  wire logic        cfg_hot,
  input  wire logic [12:0] cfg_mr,
  input  wire logic [12:0] cfg_emr,
  input  wire logic        upd_req,
  input  wire logic        upd_hot,
  input  wire logic        banks_idle,
  output logic             ddr_cke,
  output logic             ddr_cs_n,
  output logic             ddr_ras_n,
  output logic             ddr_cas_n,
  output logic             ddr_we_n,
  output logic [1:0]       ddr_ba,
  output logic [12:0]      ddr_addr,
  output logic             ddr_odt,
  output logic             init_done,
  output logic             cfg_err,
  output logic             upd_ack,
  output logic [3:0]       rd_lat,
  output logic [3:0]       wr_lat
);
  localparam int TW = dmci_pkg::TMR_W;
  localparam logic [TW-1:0] PWR_LD = TW'(P_POWER_CYC - 1);
  localparam logic [TW-1:0] CKE_LD = TW'(dmci_pkg::CKE_CYC - 1);
  localparam logic [TW-1:0] MRD_LD = TW'(P_MRD_CYC - 1);
  localparam logic [TW-1:0] RP_LD  = TW'(P_RP_CYC - 1);
  localparam logic [TW-1:0] RFC_LD = TW'(P_RFC_CYC - 1);

  dmci_tmr_if tmr ();
  dmci_timer u_timer (.clk(clk), .resetn(resetn), .t(tmr));

  dmci_pkg::dmci_state_type state_reg, state_next;
  logic [3:0]  cmd_reg, cmd_next;
  logic [1:0]  ba_reg, ba_next;
  logic [12:0] addr_reg, addr_next;
  logic        cke_reg, done_reg, err_reg, ack_reg;
  logic        cke_set, done_set, err_set, start_ok, dll_start, ack_set;
  logic [2:0]  al_reg, cl_reg;
  logic        hot_reg;
  logic [12:0] mr_reg, emr_reg, emr_op;
  logic [3:0]  rd_lat_reg, wr_lat_reg;
  logic [7:0]  dll_cnt_reg;
  logic        cfg_ok;

  assign cfg_ok = (cfg_al <= dmci_pkg::AL_MAX) &&
                  (cfg_cl >= dmci_pkg::CL_MIN) &&
                  ({1'b0, cfg_al} <= cfg_trcd);

  // operating ext value: dll on, al placed, calibration bits cleared
  assign emr_op = (emr_reg & dmci_pkg::EMR_USER_MASK) |
                  (13'(al_reg) << dmci_pkg::AL_POS);

  always_comb begin
    state_next = state_reg;
    cmd_next   = dmci_pkg::CMD_NOP;
    ba_next    = '0;
    addr_next  = '0;
    tmr.load   = 1'b0;
    tmr.value  = '0;
    cke_set    = 1'b0;
    done_set   = 1'b0;
    err_set    = 1'b0;
    start_ok   = 1'b0;
    dll_start  = 1'b0;
    ack_set    = 1'b0;
    case (state_reg)
      dmci_pkg::ST_IDLE: begin
        if (init_start && cfg_ok) begin
          start_ok   = 1'b1;
          tmr.load   = 1'b1;
          tmr.value  = PWR_LD;
          state_next = dmci_pkg::ST_PWR;
        end else if (init_start) begin
          err_set = 1'b1;
        end
      end
      dmci_pkg::ST_PWR: begin
        if (tmr.done) begin
          cke_set    = 1'b1;
          tmr.load   = 1'b1;
          tmr.value  = CKE_LD;
          state_next = dmci_pkg::ST_CKEW;
        end
      end
      dmci_pkg::ST_CKEW, dmci_pkg::ST_MRST: begin
        // the dll reset load sits in this branch only to share the gap
        if (tmr.done && state_reg == dmci_pkg::ST_CKEW) begin
          cmd_next = dmci_pkg::CMD_PRE;
          addr_next[dmci_pkg::A10_POS] = 1'b1;
          tmr.load   = 1'b1;
          tmr.value  = RP_LD;
          state_next = dmci_pkg::ST_EMR2;
        end else if (tmr.done) begin
          cmd_next  = dmci_pkg::CMD_LM;
          ba_next   = dmci_pkg::BA_MR;
          addr_next[dmci_pkg::DLLRST_POS] = 1'b1;
          dll_start  = 1'b1;
          tmr.load   = 1'b1;
          tmr.value  = MRD_LD;
          state_next = dmci_pkg::ST_PRE2;
        end
      end
      dmci_pkg::ST_EMR2: begin
        if (tmr.done) begin
          cmd_next  = dmci_pkg::CMD_LM;
          ba_next   = dmci_pkg::BA_EMR2;
          addr_next[dmci_pkg::SRF_POS] = hot_reg;
          tmr.load   = 1'b1;
          tmr.value  = MRD_LD;
          state_next = dmci_pkg::ST_EMR3;
        end
      end
      dmci_pkg::ST_EMR3: begin
        if (tmr.done) begin
          cmd_next   = dmci_pkg::CMD_LM;
          ba_next    = dmci_pkg::BA_EMR3;
          tmr.load   = 1'b1;
          tmr.value  = MRD_LD;
          state_next = dmci_pkg::ST_EDLL;
        end
      end
      dmci_pkg::ST_EDLL: begin
        if (tmr.done) begin
          // address all zero: dll enabled, optional bits left low
          cmd_next   = dmci_pkg::CMD_LM;
          ba_next    = dmci_pkg::BA_EMR;
          tmr.load   = 1'b1;
          tmr.value  = MRD_LD;
          state_next = dmci_pkg::ST_MRST;
        end
      end
      dmci_pkg::ST_PRE2: begin
        if (tmr.done) begin
          cmd_next = dmci_pkg::CMD_PRE;
          addr_next[dmci_pkg::A10_POS] = 1'b1;
          tmr.load   = 1'b1;
          tmr.value  = RP_LD;
          state_next = dmci_pkg::ST_REF1;
        end
      end
      dmci_pkg::ST_REF1, dmci_pkg::ST_REF2: begin
        if (tmr.done) begin
          cmd_next   = dmci_pkg::CMD_REF;
          tmr.load   = 1'b1;
          tmr.value  = RFC_LD;
          state_next = (state_reg == dmci_pkg::ST_REF1) ?
                       dmci_pkg::ST_REF2 : dmci_pkg::ST_MROP;
        end
      end
      dmci_pkg::ST_MROP: begin
        if (tmr.done) begin
          cmd_next  = dmci_pkg::CMD_LM;
          ba_next   = dmci_pkg::BA_MR;
          // dll reset bit stays low by the mask
          addr_next = (mr_reg & dmci_pkg::MR_USER_MASK) |
                      (13'(cl_reg) << dmci_pkg::CL_POS);
          tmr.load   = 1'b1;
          tmr.value  = MRD_LD;
          state_next = dmci_pkg::ST_OCDD;
        end
      end
      dmci_pkg::ST_OCDD, dmci_pkg::ST_OCDX: begin
        if (tmr.done) begin
          cmd_next  = dmci_pkg::CMD_LM;
          ba_next   = dmci_pkg::BA_EMR;
          addr_next = emr_op;
          // only default then exit; calibration steps are never sent
          if (state_reg == dmci_pkg::ST_OCDD) begin
            addr_next[dmci_pkg::OCD_POS +: 3] = dmci_pkg::OCD_DEFAULT;
          end
          tmr.load   = 1'b1;
          tmr.value  = MRD_LD;
          state_next = (state_reg == dmci_pkg::ST_OCDD) ?
                       dmci_pkg::ST_OCDX : dmci_pkg::ST_LOCK;
        end
      end
      dmci_pkg::ST_LOCK: begin
        if (tmr.done && dll_cnt_reg == '0) begin
          done_set   = 1'b1;
          state_next = dmci_pkg::ST_DONE;
        end
      end
      dmci_pkg::ST_DONE: begin
        if (upd_req) begin
          state_next = dmci_pkg::ST_UPD;
        end
      end
      dmci_pkg::ST_UPD: begin
        // user must hold off accesses; wait for idle banks anyway
        if (tmr.done && banks_idle) begin
          cmd_next  = dmci_pkg::CMD_LM;
          ba_next   = dmci_pkg::BA_EMR2;
          addr_next[dmci_pkg::SRF_POS] = hot_reg;
          tmr.load   = 1'b1;
          tmr.value  = MRD_LD;
          state_next = dmci_pkg::ST_UWT;
        end
      end
      dmci_pkg::ST_UWT: begin
        if (tmr.done) begin
          ack_set    = 1'b1;
          state_next = dmci_pkg::ST_DONE;
        end
      end
      default: state_next = dmci_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= dmci_pkg::ST_IDLE;
      cmd_reg   <= dmci_pkg::CMD_NOP;
      ba_reg    <= '0;
      addr_reg  <= '0;
    end else begin
      state_reg <= state_next;
      cmd_reg   <= cmd_next;
      ba_reg    <= ba_next;
      addr_reg  <= addr_next;
    end
  end

  // cke is only ever set; nothing in the sequence lowers it again
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cke_reg  <= 1'b0;
      done_reg <= 1'b0;
      err_reg  <= 1'b0;
      ack_reg  <= 1'b0;
    end else begin
      cke_reg  <= cke_reg | cke_set;
      done_reg <= done_reg | done_set;
      err_reg  <= err_set ? 1'b1 : (start_ok ? 1'b0 : err_reg);
      ack_reg  <= ack_set;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      al_reg     <= '0;
      cl_reg     <= dmci_pkg::CL_MIN;
      hot_reg    <= 1'b0;
      mr_reg     <= '0;
      emr_reg    <= '0;
      rd_lat_reg <= '0;
      wr_lat_reg <= '0;
    end else if (start_ok) begin
      al_reg     <= cfg_al;
      cl_reg     <= cfg_cl;
      hot_reg    <= cfg_hot;
      mr_reg     <= cfg_mr;
      emr_reg    <= cfg_emr;
      rd_lat_reg <= 4'(cfg_al) + 4'(cfg_cl);
      wr_lat_reg <= 4'(cfg_al) + 4'(cfg_cl) - 4'h1;
    end else if (state_reg == dmci_pkg::ST_DONE && upd_req) begin
      hot_reg <= upd_hot;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dll_cnt_reg <= '0;
    end else if (dll_start) begin
      dll_cnt_reg <= 8'(dmci_pkg::DLL_LOCK_CYC);
    end else if (dll_cnt_reg != '0) begin
      dll_cnt_reg <= dll_cnt_reg - 8'h1;
    end
  end

  assign ddr_cke   = cke_reg;
  assign {ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n} = cmd_reg;
  assign ddr_ba    = ba_reg;
  assign ddr_addr  = addr_reg;
  assign ddr_odt   = 1'b0;
  assign init_done = done_reg;
  assign cfg_err   = err_reg;
  assign upd_ack   = ack_reg;
  assign rd_lat    = rd_lat_reg;
  assign wr_lat    = wr_lat_reg;

  // checking helpers
  logic [14:0] low_cnt;
  logic [5:0]  cke_age;
  logic [3:0]  lm_age;
  logic [1:0]  ref_cnt;
  logic [7:0]  rst_age;
  logic        pre_seen, is_lm;
  assign is_lm = (cmd_reg == dmci_pkg::CMD_LM);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      low_cnt  <= '0;
      cke_age  <= '0;
      lm_age   <= 4'hf;
      ref_cnt  <= '0;
      rst_age  <= '0;
      pre_seen <= 1'b0;
    end else begin
      if (state_reg == dmci_pkg::ST_PWR && low_cnt != 15'h7fff)
        low_cnt <= low_cnt + 15'h1;
      if (cke_reg && cke_age != 6'h3f)
        cke_age <= cke_age + 6'h1;
      lm_age <= is_lm ? 4'h1 : (lm_age == 4'hf ? lm_age : lm_age + 4'h1);
      if (cmd_reg == dmci_pkg::CMD_PRE)
        pre_seen <= 1'b1;
      if (cmd_reg == dmci_pkg::CMD_REF && ref_cnt != 2'h3)
        ref_cnt <= ref_cnt + 2'h1;
      if (is_lm && ba_reg == dmci_pkg::BA_MR && addr_reg[8])
        rst_age <= 8'h1;
      else if (rst_age != '0 && rst_age != 8'hff)
        rst_age <= rst_age + 8'h1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_ocd_default;
    is_lm && ba_reg == dmci_pkg::BA_EMR && addr_reg[9:7] == 3'h7;
  endsequence
  sequence s_ocd_exit;
    is_lm && ba_reg == dmci_pkg::BA_EMR && addr_reg[9:7] == 3'h0;
  endsequence

  a_nop_while_low: assert property (!ddr_cke |-> cmd_reg == 4'h7)
    else $error("command other than nop while cke low");
  a_cke_power_wait: assert property ($rose(ddr_cke) |-> low_cnt >= 15'(P_POWER_CYC - 1))
    else $error("cke raised before power wait");
  a_cke_held_high: assert property (ddr_cke |=> ddr_cke)
    else $error("cke dropped during bring-up");
  a_first_pre_wait: assert property (cmd_reg == 4'h2 && !pre_seen |-> cke_age >= 6'h28)
    else $error("first precharge too early after cke");
  a_pre_all_banks: assert property (cmd_reg == 4'h2 |-> addr_reg[10])
    else $error("precharge without all-bank bit");
  a_emr2_bits: assert property (is_lm && ba_reg == 2'h2 |-> (addr_reg & 13'h1f7f) == '0)
    else $error("emr2 load with reserved bits set");
  a_emr3_zero: assert property (is_lm && ba_reg == 2'h3 |-> addr_reg == '0)
    else $error("emr3 load not zero");
  a_dll_enable: assert property (is_lm && ba_reg == 2'h3 && !done_reg |=> ##[1:16] is_lm && ba_reg == 2'h1 && addr_reg == '0)
    else $error("dll enable load missing after emr3");
  a_dll_reset_load: assert property (is_lm && ba_reg == 2'h0 && addr_reg[8] |-> addr_reg == 13'h100 && ddr_cke)
    else $error("dll reset load malformed");
  a_two_refresh: assert property (is_lm && ba_reg == 2'h0 && !addr_reg[8] |-> ref_cnt >= 2'h2 && addr_reg[6:4] >= 3'h3)
    else $error("operating mode load before two refreshes");
  a_mrd_spacing: assert property (cmd_reg != 4'h7 && lm_age != 4'hf |-> lm_age >= 4'(P_MRD_CYC))
    else $error("command inside tMRD after mode load");
  a_ocd_sequence: assert property (s_ocd_default |-> ##[1:16] s_ocd_exit)
    else $error("driver default not followed by exit");
  a_ocd_legal: assert property (is_lm && ba_reg == 2'h1 |-> addr_reg[9:7] inside {3'h0, 3'h7} && addr_reg[5:3] <= 3'h6)
    else $error("illegal driver or latency field");
  a_ready_after_lock: assert property ($rose(init_done) |-> rst_age > 8'hc8)
    else $error("ready before dll lock time");
  a_latency_pair: assert property (init_done |-> wr_lat == rd_lat - 4'h1 && rd_lat == 4'(al_reg) + 4'(cl_reg) && al_reg <= 3'h6)
    else $error("latency outputs inconsistent");
  // a runtime reload must only be issued while the user reports idle banks
  a_upd_banks_idle: assert property (is_lm && ba_reg == 2'h2 && done_reg |-> $past(banks_idle))
    else $error("emr2 reload while banks busy");
endmodule

// file: sim/dmci_dev_model.sv
// behavioural ddr2 device: mode registers and a log of bus commands
`timescale 1ns/100ps
module dmci_dev_model (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        ddr_cke,
  input  wire logic        ddr_cs_n,
  input  wire logic        ddr_ras_n,
  input  wire logic        ddr_cas_n,
  input  wire logic        ddr_we_n,
  input  wire logic [1:0]  ddr_ba,
  input  wire logic [12:0] ddr_addr,
  output logic [3:0]       rl,
  output logic [3:0]       wl
);
  logic [3:0]  cmd;
  logic [12:0] mode_reg [4];
  logic [3:0]  lg_cmd [32];
  logic [12:0] lg_addr [32];
  logic [1:0]  lg_ba [32];
  int          lg_cyc [32];
  int          n_cmd;
  int          cyc;
  int          cke_cyc;
  bit          cke_up;
  bit          cke_fell;

  assign cmd = {ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n};
  // a read or write waits al clocks inside, so read data trails it by al + cl, write data by one less
  assign rl = 4'(mode_reg[1][5:3]) + 4'(mode_reg[0][6:4]);
  assign wl = rl - 4'h1;

  // the controller's reset is not a power loss, so contents survive it
  initial begin
    for (int i = 0; i < 4; i++) begin
      mode_reg[i] = 13'h0000;
    end
  end

  always @(posedge clk) begin
    // bank bits pick the target; it holds until loaded again
    if (cmd == dmci_pkg::CMD_LM) begin
      mode_reg[ddr_ba] <= ddr_addr;
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      n_cmd <= 0;
      cyc <= 0;
      cke_up <= 1'b0;
      cke_fell <= 1'b0;
    end else begin
      cyc <= cyc + 1;
      if (ddr_cke && !cke_up) begin
        cke_up <= 1'b1;
        cke_cyc <= cyc;
      end
      cke_fell <= cke_fell | (cke_up & !ddr_cke);
      if (!ddr_cs_n && cmd != dmci_pkg::CMD_NOP && n_cmd < 32) begin
        lg_cmd[n_cmd] <= cmd;
        lg_ba[n_cmd] <= ddr_ba;
        lg_addr[n_cmd] <= ddr_addr;
        lg_cyc[n_cmd] <= cyc;
        n_cmd <= n_cmd + 1;
      end
    end
  end
endmodule

// file: sim/tb.sv
// self-checking bench for the ddr2 bring-up controller
`timescale 1ns/100ps
module tb;
  localparam int PWR = 50;
  localparam int MRD = dmci_pkg::MRD_CYC;
  localparam int RP  = dmci_pkg::RP_CYC;
  localparam int RFC = dmci_pkg::RFC_CYC;
  localparam int LIM = 2000;
  logic        clk = 1'b0;
  logic        resetn;
  logic        init_start;
  logic        cfg_hot;
  logic        upd_req;
  logic        upd_hot;
  logic        banks_idle;
  logic [2:0]  cfg_cl;
  logic [2:0]  cfg_al;
  logic [3:0]  cfg_trcd;
  logic [12:0] cfg_mr;
  logic [12:0] cfg_emr;
  logic        ddr_cke;
  logic        ddr_cs_n;
  logic        ddr_ras_n;
  logic        ddr_cas_n;
  logic        ddr_we_n;
  logic        ddr_odt;
  logic        init_done;
  logic        cfg_err;
  logic        upd_ack;
  logic [1:0]  ddr_ba;
  logic [12:0] ddr_addr;
  logic [3:0]  rd_lat;
  logic [3:0]  wr_lat;
  logic [2:0]  bcl [3] = '{3'h3, 3'h2, 3'h5};
  logic [2:0]  bal [3] = '{3'h7, 3'h0, 3'h3};
  logic [3:0]  btr [3] = '{4'h7, 4'h4, 4'h2};
  logic [2:0]  gcl [3] = '{3'h5, 3'h7, 3'h3};
  logic [2:0]  gal [3] = '{3'h2, 3'h6, 3'h0};
  logic [3:0]  gtr [3] = '{4'h4, 4'h6, 4'h0};
  logic        ghot [3] = '{1'b1, 1'b0, 1'b1};
  int          failures;
  int          comparisons;
  int          st;
  int          k;

  always #5 clk = ~clk;

  dmci_init_ctrl #(.P_POWER_CYC(PWR)) u_dmci_init_ctrl (
    .clk, .resetn, .init_start, .cfg_cl, .cfg_al, .cfg_trcd, .cfg_hot,
    .cfg_mr, .cfg_emr, .upd_req, .upd_hot, .banks_idle, .ddr_cke,
    .ddr_cs_n, .ddr_ras_n, .ddr_cas_n, .ddr_we_n, .ddr_ba, .ddr_addr,
    .ddr_odt, .init_done, .cfg_err, .upd_ack, .rd_lat, .wr_lat
  );
  dmci_dev_model u_dmci_dev_model (
    .clk, .resetn, .ddr_cke, .ddr_cs_n, .ddr_ras_n, .ddr_cas_n,
    .ddr_we_n, .ddr_ba, .ddr_addr, .rl(), .wl()
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // inputs always move one step after the rising edge
  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic do_reset();
    resetn = 1'b0;
    cycles(8);
    check(ddr_cke, 1'b0);
    check({ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n},
          dmci_pkg::CMD_NOP);
    resetn = 1'b1;
  endtask

  task automatic start(input logic [2:0] cl, input logic [2:0] al,
                       input logic [3:0] trcd, input logic hot);
    cfg_cl = cl;
    cfg_al = al;
    cfg_trcd = trcd;
    cfg_hot = hot;
    init_start = 1'b1;
    cycles(1);
    st = u_dmci_dev_model.cyc - 1;
    init_start = 1'b0;
  endtask

  task automatic wait_hi(input bit ack);
    for (k = 0; k < LIM; k++) begin
      if (ack ? upd_ack === 1'b1 : init_done === 1'b1) break;
      cycles(1);
    end
    if (k == LIM) begin
      failures++;
      tally_and_finish();
    end
  endtask

  task automatic check_seq(input logic [2:0] cl, input logic [2:0] al,
                           input logic hot);
    logic [12:0] mrv;
    logic [12:0] emv;
    logic [3:0]  ec [11];
    logic [1:0]  eb [11];
    logic [12:0] ea [11];
    int          eg [11];
    int          prev;
    mrv = (cfg_mr & dmci_pkg::MR_USER_MASK) | {6'h00, cl, 4'h0};
    emv = (cfg_emr & dmci_pkg::EMR_USER_MASK) | {7'h00, al, 3'h0};
    ec = '{4'h2, 4'h0, 4'h0, 4'h0, 4'h0, 4'h2, 4'h1, 4'h1, 4'h0, 4'h0, 4'h0};
    eb = '{2'h0, 2'h2, 2'h3, 2'h1, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h1};
    eg = '{dmci_pkg::CKE_CYC, RP, MRD, MRD, MRD, MRD, RP, RFC, RFC, MRD, MRD};
    ea = '{13'h0400, {5'h00, hot, 7'h00}, 13'h0000, 13'h0000, 13'h0100,
           13'h0400, 13'h0000, 13'h0000, mrv, emv | 13'h0380, emv};
    check(u_dmci_dev_model.n_cmd, 11);
    prev = u_dmci_dev_model.cke_cyc;
    for (int j = 0; j < 11; j++) begin
      check(u_dmci_dev_model.lg_cmd[j], ec[j]);
      check(u_dmci_dev_model.lg_cyc[j] - prev, eg[j]);
      if (ec[j] == dmci_pkg::CMD_LM) begin
        check(u_dmci_dev_model.lg_ba[j], eb[j]);
        check(u_dmci_dev_model.lg_addr[j], ea[j]);
      end else if (ec[j] == dmci_pkg::CMD_PRE) begin
        check(u_dmci_dev_model.lg_addr[j][10], 1'b1);
      end
      prev = u_dmci_dev_model.lg_cyc[j];
    end
  endtask

  initial begin
    {init_start, upd_req, upd_hot, cfg_hot} = 4'h0;
    banks_idle = 1'b1;
    {cfg_cl, cfg_al, cfg_trcd} = 10'h000;
    cfg_mr = 13'h1fff;
    cfg_emr = 13'h1fff;
    do_reset();
    // an update before bring-up must stay off the bus
    upd_req = 1'b1;
    cycles(1);
    upd_req = 1'b0;
    cycles(4);
    check(u_dmci_dev_model.n_cmd, 0);
    for (int i = 0; i < 3; i++) begin
      start(bcl[i], bal[i], btr[i], 1'b0);
      cycles(1);
      check(cfg_err, 1'b1);
      check(ddr_cke, 1'b0);
    end
    for (int i = 0; i < 3; i++) begin
      do_reset();
      if (i == 2) begin
        // abort mid-sequence, after cke has risen
        start(3'h4, 3'h1, 4'h3, 1'b0);
        cycles(PWR + 45);
        do_reset();
      end
      start(gcl[i], gal[i], gtr[i], ghot[i]);
      cycles(1);
      check(cfg_err, 1'b0);
      check(rd_lat, 4'(gal[i]) + 4'(gcl[i]));
      check(wr_lat, 4'(gal[i]) + 4'(gcl[i]) - 4'h1);
      wait_hi(1'b0);
      k = u_dmci_dev_model.cke_cyc - st;
      check(k >= PWR && k <= PWR + 1, 1'b1);
      k = u_dmci_dev_model.cyc - u_dmci_dev_model.lg_cyc[4];
      check(k >= 200, 1'b1);
      check_seq(gcl[i], gal[i], ghot[i]);
      check(u_dmci_dev_model.rl, 4'(gal[i]) + 4'(gcl[i]));
      check(u_dmci_dev_model.wl, 4'(gal[i]) + 4'(gcl[i]) - 4'h1);
      check(u_dmci_dev_model.cke_fell, 1'b0);
      check(ddr_odt, 1'b0);
      banks_idle = 1'b0;
      upd_hot = ~ghot[i];
      upd_req = 1'b1;
      cycles(1);
      upd_req = 1'b0;
      cycles(6);
      check(u_dmci_dev_model.n_cmd, 11);
      banks_idle = 1'b1;
      wait_hi(1'b1);
      check(u_dmci_dev_model.n_cmd, 12);
      k = u_dmci_dev_model.cyc - u_dmci_dev_model.lg_cyc[11];
      check(k, MRD);
      check(u_dmci_dev_model.mode_reg[2], {5'h00, ~ghot[i], 7'h00});
      check(u_dmci_dev_model.mode_reg[3], 13'h0000);
    end
    tally_and_finish();
  end
endmodule
